// file: verilog/sef_spi_front.sv
/*
 * Serial front end of a byte-wide EEPROM: select qualification, pause,
 * MSB-first shifting in and out, volatile flags, Wishbone register file.
 * Assumes clk much faster than the serial clock (eight or more cycles
 * per serial bit) and that array access lies behind the registers.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sef_consts.svh"
module sef_spi_front (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sclk,
    input  wire logic        csn,
    input  wire logic        hold_n,
    input  wire logic        sdi,
    input  wire logic        wp_n,
    output logic             sdo,
    output logic             sdo_oe,
    input  wire logic [2:0]  nv_status_i,
    output logic             nv_wr_o,
    output logic      [2:0]  nv_data_o,
    output logic             standby_o,
    output logic             active_o
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisation

    sef_pkg::sef_pins_t pin_raw;
    sef_pkg::sef_pins_t p;
    sef_pkg::sef_pins_t pr;
    sef_pkg::sef_pins_t pf;

    assign pin_raw = sef_pkg::sef_pins_t'({sclk, csn, hold_n, sdi, wp_n});

    sef_sync u_sync (
        .clk    (clk),
        .rstn   (rstn),
        .pin_i  (pin_raw),
        .lvl_o  (p),
        .rise_o (pr),
        .fall_o (pf)
    );

////////////////////////////////////////////////////////////////////////
// Link state

    sef_pkg::sef_state_t st_reg;
    sef_pkg::sef_state_t st_next;
    logic       armed_reg;
    logic       armed_next;
    logic       paused_reg;
    logic       paused_next;
    logic [2:0] bit_reg;
    logic [2:0] bit_next;
    logic [1:0] addr_reg;
    logic [1:0] addr_next;
    logic [7:0] byte_reg;
    logic [7:0] byte_next;
    logic [7:0] instr_reg;
    logic [7:0] instr_next;
    logic [7:0] rxd_reg;
    logic [7:0] rxd_next;
    logic       use_tx_reg;
    logic       use_tx_next;
    logic       sdo_reg;
    logic       sdo_next;

    logic       selected;
    logic       go;
    logic       rx_sh;
    logic       byte_done;
    logic       tx_fall;
    logic       tx_ld;
    logic       tx_sh;
    logic       tx_take;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [7:0] rx_byte;
    logic [7:0] src_byte;
    logic [7:0] status_byte;
    logic [7:0] tx_data_reg;
    logic       wl_reg;
    logic       busy_reg;

    // Level select counts only once a falling edge has armed the input
    assign selected  = armed_reg & ~p.csn;
    assign go        = selected & ~paused_reg;
    assign rx_sh     = go & pr.sclk;
    assign byte_done = rx_sh & (bit_reg == 3'h7);
    assign rx_byte   = {rx_q[6:0], p.sdi};
    assign tx_fall   = go & pf.sclk & (st_reg == sef_pkg::ST_DOUT);
    assign tx_ld     = tx_fall & (bit_reg == 3'h0);
    assign tx_sh     = tx_fall & (bit_reg != 3'h0);
    assign tx_take   = tx_ld & use_tx_reg;
    assign src_byte  = use_tx_reg ? tx_data_reg : status_byte;

    always_comb begin
        status_byte = `SEF_RST_BYTE;
        status_byte[`SEF_SR_BUSY]   = busy_reg;
        status_byte[`SEF_SR_WLATCH] = wl_reg;
        status_byte[`SEF_SR_PLO]    = nv_status_i[`SEF_NV_PLO];
        status_byte[`SEF_SR_PHI]    = nv_status_i[`SEF_NV_PHI];
        status_byte[`SEF_SR_LOCK]   = nv_status_i[`SEF_NV_LOCK];
    end

    sef_shift u_rx (
        .clk    (clk),
        .rstn   (rstn),
        .clr    (~selected),
        .ld     (1'b0),
        .sh     (rx_sh),
        .din    (p.sdi),
        .ld_val (`SEF_RST_BYTE),
        .q      (rx_q)
    );

    sef_shift u_tx (
        .clk    (clk),
        .rstn   (rstn),
        .clr    (~selected),
        .ld     (tx_ld),
        .sh     (tx_sh),
        .din    (1'b0),
        .ld_val (src_byte),
        .q      (tx_q)
    );

    always_comb begin
        st_next     = st_reg;
        armed_next  = armed_reg | pf.csn;
        paused_next = paused_reg;
        bit_next    = bit_reg;
        addr_next   = addr_reg;
        byte_next   = byte_reg;
        instr_next  = instr_reg;
        rxd_next    = rxd_reg;
        use_tx_next = use_tx_reg;
        sdo_next    = sdo_reg;
        if (!selected) begin
            // Deselect drops any pause and partial frame, flags stay
            st_next     = sef_pkg::ST_IDLE;
            paused_next = 1'b0;
            bit_next    = 3'h0;
            addr_next   = 2'h0;
            byte_next   = `SEF_RST_BYTE;
        end else begin
            // Hold edges take effect only while the clock sits low
            if (!p.sclk)
                paused_next = ~p.hold_n;
            if (st_reg == sef_pkg::ST_IDLE)
                st_next = sef_pkg::ST_CMD;
            if (rx_sh)
                bit_next = bit_reg + 3'h1;
            if (byte_done) begin
                byte_next = byte_reg + 8'h01;
                rxd_next  = rx_byte;
                case (st_reg)
                    sef_pkg::ST_IDLE, sef_pkg::ST_CMD: begin
                        instr_next = rx_byte;
                        if (rx_byte == `SEF_OP_RDSR) begin
                            st_next     = sef_pkg::ST_DOUT;
                            use_tx_next = 1'b0;
                        end else if (rx_byte == `SEF_OP_READ) begin
                            st_next = sef_pkg::ST_ADDR;
                        end else begin
                            st_next = sef_pkg::ST_DIN;
                        end
                    end
                    sef_pkg::ST_ADDR: begin
                        addr_next = addr_reg + 2'h1;
                        if (addr_reg == `SEF_ADDR_LAST) begin
                            st_next     = sef_pkg::ST_DOUT;
                            use_tx_next = 1'b1;
                        end
                    end
                    default: begin
                        st_next = st_reg;
                    end
                endcase
            end
        end
        if (tx_ld)
            sdo_next = src_byte[7];
        else if (tx_sh)
            sdo_next = tx_q[6];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg     <= sef_pkg::ST_IDLE;
            armed_reg  <= 1'b0;
            paused_reg <= 1'b0;
            bit_reg    <= 3'h0;
            addr_reg   <= 2'h0;
            byte_reg   <= `SEF_RST_BYTE;
            instr_reg  <= `SEF_RST_BYTE;
            rxd_reg    <= `SEF_RST_BYTE;
            use_tx_reg <= 1'b0;
            sdo_reg    <= 1'b0;
        end else begin
            st_reg     <= st_next;
            armed_reg  <= armed_next;
            paused_reg <= paused_next;
            bit_reg    <= bit_next;
            addr_reg   <= addr_next;
            byte_reg   <= byte_next;
            instr_reg  <= instr_next;
            rxd_reg    <= rxd_next;
            use_tx_reg <= use_tx_next;
            sdo_reg    <= sdo_next;
        end
    end

    assign sdo       = sdo_reg;
    assign sdo_oe    = go & (st_reg == sef_pkg::ST_DOUT);
    // A running write cycle keeps the part out of standby
    assign standby_o = ~selected & ~busy_reg;
    assign active_o  = selected;

////////////////////////////////////////////////////////////////////////
// Wishbone slave and volatile flags

    logic        ack_reg;
    logic        ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic        wl_next;
    logic        busy_next;
    logic        rx_full_reg;
    logic        rx_full_next;
    logic [7:0]  tx_data_next;
    logic        tx_rdy_reg;
    logic        tx_rdy_next;
    logic        tx_und_reg;
    logic        tx_und_next;
    logic        nv_err_reg;
    logic        nv_err_next;
    logic        nv_wr_reg;
    logic        nv_wr_next;
    logic [2:0]  nv_dat_reg;
    logic [2:0]  nv_dat_next;

    logic        req;
    logic        take;
    logic        wr;
    logic        frozen;
    logic [31:0] rd_mux;

    assign req  = wb_cyc_i & wb_stb_i;
    // Read data is captured at take so a byte landing then is not lost
    assign take = req & ~ack_reg;
    assign wr   = req & ack_reg & wb_we_i & wb_sel_i[0];
    // Lock bit plus low protect pin freezes the protect bits
    assign frozen = nv_status_i[`SEF_NV_LOCK] & ~p.wp_n;

    always_comb begin
        case (wb_adr_i)
            `SEF_ADR_STATUS: rd_mux = {19'h0, nv_err_reg, p.wp_n,
                                       paused_reg, selected, armed_reg,
                                       status_byte};
            `SEF_ADR_RXDATA: rd_mux = {23'h0, rx_full_reg, rxd_reg};
            `SEF_ADR_TXDATA: rd_mux = {22'h0, tx_und_reg, tx_rdy_reg,
                                       tx_data_reg};
            `SEF_ADR_NVWR:   rd_mux = {29'h0, nv_dat_reg};
            `SEF_ADR_FRAME:  rd_mux = {16'h0, byte_reg, instr_reg};
            default:         rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        ack_next     = take;
        dat_next     = (take & ~wb_we_i) ? rd_mux : dat_reg;
        wl_next      = wl_reg;
        busy_next    = busy_reg;
        tx_data_next = tx_data_reg;
        nv_wr_next   = 1'b0;
        nv_dat_next  = nv_dat_reg;
        nv_err_next  = nv_err_reg;
        tx_und_next  = tx_und_reg;
        if (wr && wb_adr_i == `SEF_ADR_CTRL) begin
            wl_next   = (wl_reg & ~wb_dat_i[`SEF_CT_WL_CLR])
                        | wb_dat_i[`SEF_CT_WL_SET];
            busy_next = (busy_reg & ~wb_dat_i[`SEF_CT_BUSY_CLR])
                        | wb_dat_i[`SEF_CT_BUSY_SET];
            if (wb_dat_i[`SEF_CT_UND_CLR])
                tx_und_next = 1'b0;
            if (wb_dat_i[`SEF_CT_ERR_CLR])
                nv_err_next = 1'b0;
        end
        if (wr && wb_adr_i == `SEF_ADR_TXDATA)
            tx_data_next = wb_dat_i[7:0];
        if (wr && wb_adr_i == `SEF_ADR_NVWR) begin
            if (frozen) begin
                nv_err_next = 1'b1;
            end else begin
                nv_wr_next  = 1'b1;
                nv_dat_next = wb_dat_i[2:0];
            end
        end
        // Hardware events win over a clear in the same cycle
        if (tx_take & ~tx_rdy_reg)
            tx_und_next = 1'b1;
        rx_full_next = byte_done | (rx_full_reg & ~(take & ~wb_we_i
                       & (wb_adr_i == `SEF_ADR_RXDATA)));
        tx_rdy_next  = (wr & (wb_adr_i == `SEF_ADR_TXDATA))
                       | (tx_rdy_reg & ~tx_take);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg     <= 1'b0;
            dat_reg     <= 32'h0;
            wl_reg      <= 1'b0;
            busy_reg    <= 1'b0;
            rx_full_reg <= 1'b0;
            tx_data_reg <= `SEF_RST_BYTE;
            tx_rdy_reg  <= 1'b0;
            tx_und_reg  <= 1'b0;
            nv_err_reg  <= 1'b0;
            nv_wr_reg   <= 1'b0;
            nv_dat_reg  <= 3'h0;
        end else begin
            ack_reg     <= ack_next;
            dat_reg     <= dat_next;
            wl_reg      <= wl_next;
            busy_reg    <= busy_next;
            rx_full_reg <= rx_full_next;
            tx_data_reg <= tx_data_next;
            tx_rdy_reg  <= tx_rdy_next;
            tx_und_reg  <= tx_und_next;
            nv_err_reg  <= nv_err_next;
            nv_wr_reg   <= nv_wr_next;
            nv_dat_reg  <= nv_dat_next;
        end
    end

    assign wb_ack_o  = ack_reg;
    assign wb_dat_o  = dat_reg;
    assign nv_wr_o   = nv_wr_reg;
    assign nv_data_o = nv_dat_reg;

////////////////////////////////////////////////////////////////////////
// Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_oe_when_idle: assert property (
        !selected |-> !sdo_oe)
        else $error("output enabled while deselected");
    a_sdo_on_fall: assert property (
        $changed(sdo_reg) |-> $past(pf.sclk))
        else $error("serial output moved without a falling clock");
    a_arm_by_fall: assert property (
        $rose(armed_reg) |-> $past(pf.csn))
        else $error("select armed without a falling edge");
    a_pause_freezes: assert property (
        (paused_reg && pr.sclk) |=> $stable(bit_reg) && $stable(rx_q))
        else $error("clock edge shifted during pause");
    a_rx_msb_first: assert property (
        (rx_sh && !byte_done) |=> rx_q[0] == $past(p.sdi)
                                  && rx_q[7:1] == $past(rx_q[6:0]))
        else $error("input bit not shifted in at the bottom");
    a_load_msb: assert property (
        tx_ld |=> sdo_reg == $past(src_byte[7]) ##1 $stable(sdo_reg))
        else $error("first output bit is not the MSB");
    a_por_clear: assert property (
        $rose(rstn) |-> !wl_reg && !busy_reg && st_reg == sef_pkg::ST_IDLE)
        else $error("volatile flags not clear after reset");
    a_deselect_reset: assert property (
        (paused_reg && !selected) |=> !paused_reg && bit_reg == 3'h0
                                      && st_reg == sef_pkg::ST_IDLE)
        else $error("deselect in pause did not reset interface");
    a_nv_frozen: assert property (
        nv_wr_o |-> !$past(frozen))
        else $error("protect bits written while frozen");
    a_pause_entry: assert property (
        (selected && !p.sclk && !p.hold_n) |=> paused_reg)
        else $error("pause not entered with clock low");

    c_rdsr_out: cover property (
        (st_reg == sef_pkg::ST_DOUT && !use_tx_reg) ##[1:300] tx_ld);
    c_read_out: cover property (tx_take);
    c_pause: cover property ($rose(paused_reg) ##[1:300] $fell(paused_reg));
    c_nv_write: cover property (nv_wr_o);

endmodule : sef_spi_front
`default_nettype wire

// file: verilog/sef_consts.svh
/*
 * Constants of the serial EEPROM front end: register byte offsets,
 * field positions, reset values and opcodes.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef SEF_CONSTS_SVH
`define SEF_CONSTS_SVH

`define SEF_ADR_CTRL    8'h00
`define SEF_ADR_STATUS  8'h04
`define SEF_ADR_RXDATA  8'h08
`define SEF_ADR_TXDATA  8'h0C
`define SEF_ADR_NVWR    8'h10
`define SEF_ADR_FRAME   8'h14

`define SEF_CT_WL_SET   0
`define SEF_CT_WL_CLR   1
`define SEF_CT_BUSY_SET 2
`define SEF_CT_BUSY_CLR 3
`define SEF_CT_UND_CLR  4
`define SEF_CT_ERR_CLR  5

`define SEF_SR_BUSY     0
`define SEF_SR_WLATCH   1
`define SEF_SR_PLO      2
`define SEF_SR_PHI      3
`define SEF_SR_LOCK     7

`define SEF_NV_PLO      0
`define SEF_NV_PHI      1
`define SEF_NV_LOCK     2

`define SEF_OP_RDSR     8'h05
`define SEF_OP_READ     8'h03
`define SEF_ADDR_LAST   2'h1
`define SEF_PIN_RST     5'h05
`define SEF_RST_BYTE    8'h00

`endif

// file: verilog/sef_pkg.sv
/*
 * Types shared by the serial EEPROM front end modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sef_pkg;

    // Field order fixes the bit order of the pin vector
    typedef struct packed {
        logic sclk;
        logic csn;
        logic hold_n;
        logic sdi;
        logic wp_n;
    } sef_pins_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CMD  = 5'h02,
        ST_ADDR = 5'h04,
        ST_DIN  = 5'h08,
        ST_DOUT = 5'h10
    } sef_state_t;

endpackage : sef_pkg

// file: verilog/sef_sync.sv
/*
 * Three-stage synchroniser for the serial pins, with filtered level
 * and edge pulses. Assumes pins are asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sef_consts.svh"
module sef_sync (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire sef_pkg::sef_pins_t pin_i,
    output sef_pkg::sef_pins_t    lvl_o,
    output sef_pkg::sef_pins_t    rise_o,
    output sef_pkg::sef_pins_t    fall_o
);
    localparam logic [4:0] RST = `SEF_PIN_RST;
    logic [4:0] lvl_v;
    logic [4:0] rise_v;
    logic [4:0] fall_v;

    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lv_reg;
            logic lv_next;
            // Only stages two and three judge a change
            always_comb begin
                lv_next = (s2_reg == s3_reg) ? s3_reg : lv_reg;
            end
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    s1_reg <= RST[i];
                    s2_reg <= RST[i];
                    s3_reg <= RST[i];
                    lv_reg <= RST[i];
                end else begin
                    s1_reg <= pin_i[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    lv_reg <= lv_next;
                end
            end
            assign lvl_v[i]  = lv_reg;
            assign rise_v[i] = lv_next & ~lv_reg;
            assign fall_v[i] = ~lv_next & lv_reg;
        end
    endgenerate

    assign lvl_o  = sef_pkg::sef_pins_t'(lvl_v);
    assign rise_o = sef_pkg::sef_pins_t'(rise_v);
    assign fall_o = sef_pkg::sef_pins_t'(fall_v);
endmodule : sef_sync
`default_nettype wire

// file: verilog/sef_shift.sv
/*
 * Eight-bit shift register, MSB first, with clear and parallel load.
 * Assumes the caller never asserts load and shift together.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sef_consts.svh"
module sef_shift (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       clr,
    input  wire logic       ld,
    input  wire logic       sh,
    input  wire logic       din,
    input  wire logic [7:0] ld_val,
    output logic      [7:0] q
);
    logic [7:0] q_reg;
    logic [7:0] q_next;

    always_comb begin
        q_next = q_reg;
        if (clr)
            q_next = `SEF_RST_BYTE;
        else if (ld)
            q_next = ld_val;
        else if (sh)
            q_next = {q_reg[6:0], din};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            q_reg <= `SEF_RST_BYTE;
        else
            q_reg <= q_next;
    end

    assign q = q_reg;
endmodule : sef_shift
`default_nettype wire

// file: verif/sef_spi_master.sv
/*
 * Behavioural SPI bus master for the serial EEPROM front end.
 * Assumes clk is the bench clock; a serial bit is four cycles low then five high.
 */
`timescale 1ns/1ps
`default_nettype none
module sef_spi_master (
    input  wire logic clk,
    input  wire logic q,
    output logic      sclk,
    output logic      csn,
    output logic      hold_n,
    output logic      sdi,
    output logic      wp_n
);
    logic mode;
    // Select starts low on purpose: no falling edge is seen after reset
    initial begin
        mode   = 1'b0;
        sclk   = 1'b0;
        csn    = 1'b0;
        hold_n = 1'b1;
        sdi    = 1'b0;
        wp_n   = 1'b1;
    end
    task automatic set_mode(input logic m);
        @(posedge clk);
        mode <= m;
        sclk <= m;
    endtask : set_mode
    task automatic set_wp(input logic v);
        @(posedge clk);
        wp_n <= v;
        // Let the three-stage synchroniser settle before any register read
        repeat (4) @(posedge clk);
    endtask : set_wp
    task automatic begin_frame();
        @(posedge clk);
        csn <= 1'b0;
        // One edge past the synchroniser so the select level has landed
        repeat (5) @(posedge clk);
    endtask : begin_frame
    task automatic end_frame();
        @(posedge clk);
        sclk <= mode;
        repeat (4) @(posedge clk);
        csn <= 1'b1;
        sdi <= ~sdi; // Released line must not keep its last value
        repeat (8) @(posedge clk);
    endtask : end_frame
    // Output bit is taken late in the high phase, where it is settled
    task automatic bits(input int n, input logic [7:0] v,
                        output logic [7:0] r);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            sclk <= 1'b0;
            sdi  <= v[7-i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            r = {r[6:0], q};
        end
    endtask : bits
    task automatic hold(input logic v);
        @(posedge clk);
        sclk <= 1'b0;
        repeat (4) @(posedge clk);
        hold_n <= v;
        repeat (4) @(posedge clk);
    endtask : hold
endmodule : sef_spi_master
`default_nettype wire

// file: verif/test_serial_eeprom_spi_front_end.sv
/*
 * Self-checking bench of the serial EEPROM front end.
 * Assumes the partner model drives the serial pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sef_consts.svh"
module test_serial_eeprom_spi_front_end;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        sclk, csn, hold_n, sdi, wp_n, sdo, sdo_oe;
    logic        nv_wr_o, standby_o, active_o;
    logic [2:0]  nv_data_o;
    logic [7:0]  r;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          nv_cnt = 0;
    int          cyc_cnt = 0;
    logic [3:0]  wb_sel = 4'hF;
    logic [2:0]  nv_status = 3'h5;
    wire         sdo_pin = sdo_oe ? sdo : 1'bz;

    always #25 clk = ~clk;

    sef_spi_front sef_spi_front_i (.clk(clk), .rstn(rstn),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclk(sclk), .csn(csn),
        .hold_n(hold_n), .sdi(sdi), .wp_n(wp_n), .sdo(sdo), .sdo_oe(sdo_oe),
        .nv_status_i(nv_status), .nv_wr_o(nv_wr_o), .nv_data_o(nv_data_o),
        .standby_o(standby_o), .active_o(active_o));
    sef_spi_master sef_spi_master_i (.clk(clk), .q(sdo_pin), .sclk(sclk),
        .csn(csn), .hold_n(hold_n), .sdi(sdi), .wp_n(wp_n));

    ////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Checks %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////
    // Hang guard, well above the 1300 or so cycles the tests need
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        // Nonvolatile bits follow each accepted store, as the array would
        if (nv_wr_o === 1'b1) begin
            nv_cnt    <= nv_cnt + 1;
            nv_status <= nv_data_o;
        end
        if (cyc_cnt == 30000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({31'h0, standby_o}, 32'h1);
        chk({31'h0, active_o}, 32'h0);
        chk({31'h0, sdo_oe}, 32'h0);
        rd_chk(`SEF_ADR_STATUS, 32'h884);
        sef_spi_master_i.bits(8, 8'hFF, r);
        rd_chk(`SEF_ADR_FRAME, 32'h0);
        sef_spi_master_i.end_frame();
        sef_spi_master_i.begin_frame();
        chk({31'h0, active_o}, 32'h1);
        sef_spi_master_i.bits(8, 8'hA5, r);
        rd_chk(`SEF_ADR_FRAME, 32'h1A5);
        sef_spi_master_i.end_frame();
        rd_chk(`SEF_ADR_RXDATA, 32'h1A5);
        for (int m = 0; m < 2; m++) begin
            sef_spi_master_i.set_mode(m[0]);
            wr(`SEF_ADR_CTRL, m[0] ? 32'h5 : 32'h1);
            sef_spi_master_i.begin_frame();
            sef_spi_master_i.bits(8, `SEF_OP_RDSR, r);
            sef_spi_master_i.bits(8, 8'h00, r);
            chk({24'h0, r}, 32'h86 | m);
            chk({31'h0, sdo_oe}, 32'h1);
            sef_spi_master_i.end_frame();
            chk({31'h0, sdo_oe}, 32'h0);
            chk({31'h0, standby_o}, {31'h0, ~m[0]});
            wr(`SEF_ADR_CTRL, 32'h0A);
        end
        sef_spi_master_i.set_mode(1'b0);
        sef_spi_master_i.begin_frame();
        sef_spi_master_i.bits(4, 8'h5A, r);
        sef_spi_master_i.hold(1'b0);
        rd_chk(`SEF_ADR_STATUS, 32'hF84);
        chk({31'h0, sdo_oe}, 32'h0);
        sef_spi_master_i.bits(4, 8'hF0, r);
        sef_spi_master_i.hold(1'b1);
        sef_spi_master_i.bits(4, 8'hA0, r);
        sef_spi_master_i.end_frame();
        rd_chk(`SEF_ADR_RXDATA, 32'h15A);
        // Deselect while paused drops the partial byte, keeps the flags
        wr(`SEF_ADR_CTRL, 32'h1);
        sef_spi_master_i.begin_frame();
        sef_spi_master_i.bits(3, 8'hFF, r);
        sef_spi_master_i.hold(1'b0);
        sef_spi_master_i.end_frame();
        sef_spi_master_i.hold(1'b1);
        sef_spi_master_i.begin_frame();
        sef_spi_master_i.bits(8, 8'h3C, r);
        sef_spi_master_i.end_frame();
        rd_chk(`SEF_ADR_RXDATA, 32'h13C);
        rd_chk(`SEF_ADR_STATUS, 32'h986);
        // Write with the low byte lane off is ignored
        wb_sel <= 4'hE;
        wr(`SEF_ADR_TXDATA, 32'h55);
        wb_sel <= 4'hF;
        rd_chk(`SEF_ADR_TXDATA, 32'h0);
        wr(`SEF_ADR_TXDATA, 32'hC3);
        rd_chk(`SEF_ADR_TXDATA, 32'h1C3);
        sef_spi_master_i.begin_frame();
        sef_spi_master_i.bits(8, `SEF_OP_READ, r);
        sef_spi_master_i.bits(8, 8'h00, r);
        sef_spi_master_i.bits(8, 8'h00, r);
        sef_spi_master_i.bits(8, 8'h00, r);
        chk({24'h0, r}, 32'hC3);
        sef_spi_master_i.bits(8, 8'h00, r);
        chk({24'h0, r}, 32'hC3);
        sef_spi_master_i.end_frame();
        rd_chk(`SEF_ADR_TXDATA, 32'h2C3);
        wr(`SEF_ADR_CTRL, 32'h10);
        rd_chk(`SEF_ADR_TXDATA, 32'hC3);
        wr(`SEF_ADR_CTRL, 32'h2);
        sef_spi_master_i.set_wp(1'b0);
        rd_chk(`SEF_ADR_STATUS, 32'h184);
        wr(`SEF_ADR_NVWR, 32'h3);
        rd_chk(`SEF_ADR_STATUS, 32'h1184);
        chk(nv_cnt, 32'h0);
        wr(`SEF_ADR_CTRL, 32'h20);
        sef_spi_master_i.set_wp(1'b1);
        rd_chk(`SEF_ADR_STATUS, 32'h984);
        wr(`SEF_ADR_NVWR, 32'h3);
        rd_chk(8'h40, 32'h0);
        chk(nv_cnt, 32'h1);
        chk({29'h0, nv_data_o}, 32'h3);
        rd_chk(`SEF_ADR_STATUS, 32'h90C);
        finish_test();
    end
endmodule : test_serial_eeprom_spi_front_end
`default_nettype wire
